// file: inc/ccp_consts.svh
// register offsets, field positions, reset values and mode codes of the capture/compare unit
// assumes an 8-bit register address space and byte-wide registers
`ifndef CCP_CONSTS_SVH
`define CCP_CONSTS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CCP_ADDR_DATA_LATCH 8'h07
`define CCP_ADDR_FLAGS 8'h0C
`define CCP_ADDR_VALUE_LO 8'h15
`define CCP_ADDR_VALUE_HI 8'h16
`define CCP_ADDR_MODE 8'h17
`define CCP_ADDR_PIN_DIR 8'h87

// ----------------------------------------
// reset values and write masks
// ----------------------------------------
`define CCP_MODE_RESET 8'h00
`define CCP_MODE_MASK 8'h3F
`define CCP_DIR_RESET 8'hFF
`define CCP_DATA_RESET 8'h00
`define CCP_DATA_MASK 8'h05
`define CCP_BYTE_ZERO 8'h00

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCP_PIN_BIT 2
`define CCP_TCLK_BIT 0
`define CCP_FLAG_BIT 2
`define CCP_DUTY_HI_BIT 5
`define CCP_DUTY_LO_BIT 4

// ----------------------------------------
// mode select codes
// ----------------------------------------
`define CCP_M_OFF 4'h0
`define CCP_M_CAP_FALL 4'h4
`define CCP_M_CAP_RISE 4'h5
`define CCP_M_CAP_RISE4 4'h6
`define CCP_M_CAP_RISE16 4'h7
`define CCP_M_CMP_SET 4'h8
`define CCP_M_CMP_CLR 4'h9
`define CCP_M_CMP_SWI 4'hA
`define CCP_M_CMP_SPECIAL 4'hB
`define CCP_GRP_CAPTURE 2'h1
`define CCP_GRP_COMPARE 2'h2
`define CCP_GRP_PWM 2'h3

// ----------------------------------------
// capture prescale terminal counts
// ----------------------------------------
`define CCP_PS4_LAST 4'h3
`define CCP_PS16_LAST 4'hF

`endif

// file: inc/ccp_pkg.sv
// state types of the capture/compare unit and of its pin synchroniser
// assumes a 16-bit value register built from two bytes
package ccp_pkg;

  // ----------------------------------------
  // synchroniser state
  // ----------------------------------------
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } ccp_sync_state_t;

  // ----------------------------------------
  // unit state
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] dir;
    logic [7:0] dlat;
    logic [7:0] val_lo;
    logic [7:0] val_hi;
    logic [1:0] duty_lat;
    logic flag;
    logic [3:0] ps_cnt;
    logic cmp_out;
    logic match;
    logic [7:0] rdata;
    logic pin_out;
    logic pin_oe;
    logic tclk_out;
    logic tclk_oe;
    logic t1_reset;
    logic adc_start;
  } ccp_state_t;

endpackage

// file: rtl/ccp_edge_sync.sv
// two-flop synchroniser and edge detector for the unit pin
// assumes the pin level is asynchronous to mclk
`timescale 1ns/1ps
module ccp_edge_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // pin level
  input wire logic pin_async,
  // one-cycle edge pulses
  output logic rise,
  output logic fall
);

  ccp_pkg::ccp_sync_state_t s_q;
  ccp_pkg::ccp_sync_state_t s_d;

  // the first flop feeds only the second, edges are seen one stage later
  always_comb begin
    s_d = s_q;
    s_d.meta = pin_async;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync;
  end

  // state register
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // edge pulses from the settled stages
  assign rise = s_q.sync & ~s_q.last;
  assign fall = ~s_q.sync & s_q.last;

endmodule

// file: rtl/ccp_capture.sv
// capture/compare/pwm unit: mode control, pin direction, 16-bit value register and capture logic
// assumes timer counts come from logic on mclk and the pin level is resolved by the surroundings
//
// Functional notes
// - one 16-bit value register for capture, compare reference or pwm duty.
// - value built from low and high byte, both readable, both writable except the high byte in pwm modes.
// - capture and compare use the 16-bit timer, pwm uses the 8-bit timer.
// - mode register bits 7 and 6 read as zero.
// - implemented mode bits clear to zero at reset.
// - codes 0100 fall, 0101 rise, 0110 every 4th rise, 0111 every 16th rise.
// - each capture event copies the 16-bit timer count into the value bytes.
// - capture sets flag bit 2, which stays set until software clears it.
// - a later capture overwrites an unread value.
// - with the pin driven, writing its data latch can cause a capture.
// - code 1010 sets the flag on a match and leaves the pin alone.
// - special-event match resets the timer and starts a conversion.
// - direction bit 2 drives the pin when 0, tristates it when 1.
// - prescale counter clears whenever the unit is off or not capturing.
// - clearing the mode register forces the compare output latch low.
`timescale 1ns/1ps
`include "ccp_consts.svh"
module ccp_capture #(
  parameter int VALUE_W = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata,
  // timer bases
  input wire logic [15:0] timer1_count,
  input wire logic [7:0] timer2_count,
  input wire logic timer2_period_match,
  // unit pin
  input wire logic unit_pin_in,
  output logic unit_pin_out,
  output logic unit_pin_oe,
  // timer external clock pin
  output logic timer_clock_pin_out,
  output logic timer_clock_pin_oe,
  // events to the system
  output logic unit_interrupt_flag,
  output logic timer1_reset,
  output logic adc_start
);

  // ----------------------------------------
  // elaboration check
  // ----------------------------------------
  if (VALUE_W != 16) begin : g_bad_width
    $error("ccp_capture supports only a 16-bit value register");
  end

  ccp_pkg::ccp_state_t s_q;
  ccp_pkg::ccp_state_t s_d;
  logic pin_rise;
  logic pin_fall;
  logic [3:0] mode_f;
  logic is_cap;
  logic is_cmp;
  logic is_pwm;
  logic cap_evt;
  logic cmp_eq;
  logic cmp_hit;
  logic pwm_high;

  // ----------------------------------------
  // pin synchroniser
  // ----------------------------------------
  // the pin input is the resolved wire, so a driven level is seen as well
  ccp_edge_sync u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .pin_async(unit_pin_in),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  // ----------------------------------------
  // mode decode and events
  // ----------------------------------------
  // mode groups from the upper bits of the mode select field
  assign mode_f = s_q.mode[3:0];
  assign is_cap = mode_f[3:2] == `CCP_GRP_CAPTURE;
  assign is_cmp = mode_f[3:2] == `CCP_GRP_COMPARE;
  assign is_pwm = mode_f[3:2] == `CCP_GRP_PWM;

  // capture event selection
  always_comb begin
    cap_evt = 1'b0;
    unique case (mode_f)
      `CCP_M_CAP_FALL: cap_evt = pin_fall;
      `CCP_M_CAP_RISE: cap_evt = pin_rise;
      `CCP_M_CAP_RISE4: cap_evt = pin_rise && (s_q.ps_cnt == `CCP_PS4_LAST);
      `CCP_M_CAP_RISE16: cap_evt = pin_rise && (s_q.ps_cnt == `CCP_PS16_LAST);
      default: cap_evt = 1'b0;
    endcase
  end

  // compare acts once when equality begins, not on every cycle the timer holds still
  assign cmp_eq = is_cmp && (timer1_count == {s_q.val_hi, s_q.val_lo});
  assign cmp_hit = cmp_eq && !s_q.match;

  // pwm level from the buffered 10-bit duty against the 8-bit timer
  assign pwm_high = {s_q.val_hi, s_q.duty_lat} > {timer2_count, 2'b00};

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.t1_reset = 1'b0;
    s_d.adc_start = 1'b0;
    s_d.rdata = `CCP_BYTE_ZERO;
    s_d.match = cmp_eq;

    // software writes
    if (reg_we) begin
      unique case (reg_addr)
        `CCP_ADDR_MODE: s_d.mode = reg_wdata & `CCP_MODE_MASK;
        `CCP_ADDR_PIN_DIR: s_d.dir = reg_wdata;
        `CCP_ADDR_DATA_LATCH: s_d.dlat = reg_wdata & `CCP_DATA_MASK;
        `CCP_ADDR_VALUE_LO: s_d.val_lo = reg_wdata;
        `CCP_ADDR_VALUE_HI: begin
          // high byte is read-only while the pwm owns it
          if (!is_pwm) begin
            s_d.val_hi = reg_wdata;
          end
        end
        default: begin
        end
      endcase
    end

    // prescaler counts rising edges only while capturing
    if (!is_cap) begin
      s_d.ps_cnt = 4'h0;
    end else if (pin_rise) begin
      s_d.ps_cnt = cap_evt ? 4'h0 : s_d.ps_cnt + 4'h1;
    end

    // capture beats a software write to the same bytes in the same cycle
    if (is_cap && cap_evt) begin
      s_d.val_hi = timer1_count[15:8];
      s_d.val_lo = timer1_count[7:0];
    end

    // compare output latch
    if (mode_f == `CCP_M_OFF) begin
      s_d.cmp_out = 1'b0;
      s_d.duty_lat = 2'b00;
    end else if (is_pwm) begin
      s_d.cmp_out = pwm_high;
    end else if (cmp_hit) begin
      unique case (mode_f)
        `CCP_M_CMP_SET: s_d.cmp_out = 1'b1;
        `CCP_M_CMP_CLR: s_d.cmp_out = 1'b0;
        `CCP_M_CMP_SPECIAL: begin
          s_d.t1_reset = 1'b1;
          s_d.adc_start = 1'b1;
        end
        default: begin
          // software interrupt only, pin untouched
          s_d.cmp_out = s_q.cmp_out;
        end
      endcase
    end

    // pwm duty is double buffered and moves only at the period boundary
    if (is_pwm && timer2_period_match) begin
      s_d.val_hi = s_q.val_lo;
      s_d.duty_lat = s_q.mode[`CCP_DUTY_HI_BIT:`CCP_DUTY_LO_BIT];
    end

    // flag: a hardware set wins over a software clear in the same cycle
    if (reg_we && reg_addr == `CCP_ADDR_FLAGS) begin
      s_d.flag = reg_wdata[`CCP_FLAG_BIT];
    end
    if ((is_cap && cap_evt) || cmp_hit) begin
      s_d.flag = 1'b1;
    end

    // pin drivers follow the direction bits
    s_d.pin_oe = ~s_q.dir[`CCP_PIN_BIT];
    s_d.pin_out = (is_cmp || is_pwm) ? s_q.cmp_out : s_q.dlat[`CCP_PIN_BIT];
    s_d.tclk_oe = ~s_q.dir[`CCP_TCLK_BIT];
    s_d.tclk_out = s_q.dlat[`CCP_TCLK_BIT];

    // read data stands only in the cycle after the strobe; unmapped reads give zero
    if (reg_re) begin
      unique case (reg_addr)
        `CCP_ADDR_MODE: s_d.rdata = s_q.mode & `CCP_MODE_MASK;
        `CCP_ADDR_PIN_DIR: s_d.rdata = s_q.dir;
        `CCP_ADDR_DATA_LATCH: s_d.rdata = s_q.dlat;
        `CCP_ADDR_VALUE_LO: s_d.rdata = s_q.val_lo;
        `CCP_ADDR_VALUE_HI: s_d.rdata = s_q.val_hi;
        `CCP_ADDR_FLAGS: s_d.rdata = {5'h00, s_q.flag, 2'b00};
        default: s_d.rdata = `CCP_BYTE_ZERO;
      endcase
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.mode <= `CCP_MODE_RESET;
      s_q.dir <= `CCP_DIR_RESET;
      s_q.dlat <= `CCP_DATA_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign reg_rdata = s_q.rdata;
  assign unit_pin_out = s_q.pin_out;
  assign unit_pin_oe = s_q.pin_oe;
  assign timer_clock_pin_out = s_q.tclk_out;
  assign timer_clock_pin_oe = s_q.tclk_oe;
  assign unit_interrupt_flag = s_q.flag;
  assign timer1_reset = s_q.t1_reset;
  assign adc_start = s_q.adc_start;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  a_cap_copies_timer: assert property (is_cap && cap_evt |=> {s_q.val_hi, s_q.val_lo} == $past(timer1_count))
    else $error("capture did not copy the timer count");
  a_cap_sets_flag: assert property (is_cap && cap_evt |=> unit_interrupt_flag)
    else $error("capture did not set the flag");
  a_flag_held_set: assert property (unit_interrupt_flag && !(reg_we && reg_addr == `CCP_ADDR_FLAGS)
      |=> unit_interrupt_flag)
    else $error("flag dropped without a software clear");
  a_mode_top_zero: assert property (reg_re && reg_addr == `CCP_ADDR_MODE |=> reg_rdata[7:6] == 2'b00)
    else $error("unimplemented mode bits read nonzero");
  a_ps_cleared_off: assert property (!is_cap |=> s_q.ps_cnt == 4'h0)
    else $error("prescaler not cleared outside capture");
  a_rise4_spacing: assert property (mode_f == `CCP_M_CAP_RISE4 && cap_evt |-> pin_rise && s_q.ps_cnt == 4'h3)
    else $error("every-4th capture at the wrong edge count");
  a_pin_dir_drive: assert property (##1 unit_pin_oe == !$past(s_q.dir[`CCP_PIN_BIT]))
    else $error("pin enable does not follow direction bit");
  a_tclk_dir_drive: assert property (##1 timer_clock_pin_oe == !$past(s_q.dir[`CCP_TCLK_BIT]))
    else $error("timer clock pin enable does not follow direction bit");
  a_swi_pin_steady: assert property (mode_f == `CCP_M_CMP_SWI && cmp_hit |=> $stable(s_q.cmp_out) && unit_interrupt_flag)
    else $error("software interrupt compare moved the pin or missed the flag");
  a_special_pulse: assert property (mode_f == `CCP_M_CMP_SPECIAL && cmp_hit |=> timer1_reset && adc_start ##1 !timer1_reset)
    else $error("special event pulse wrong");
  a_off_latch_low: assert property (mode_f == `CCP_M_OFF |=> !s_q.cmp_out)
    else $error("compare latch not low while off");
  a_set_on_match: assert property (mode_f == `CCP_M_CMP_SET && cmp_hit |=> s_q.cmp_out ##1 unit_pin_out || !is_cmp)
    else $error("set-on-match did not raise the latch");

  c_cap_every16: cover property (mode_f == `CCP_M_CAP_RISE16 && cap_evt);
  c_cap_fall: cover property (mode_f == `CCP_M_CAP_FALL && cap_evt);
  c_cmp_clear: cover property (mode_f == `CCP_M_CMP_CLR && cmp_hit);
  c_special: cover property (mode_f == `CCP_M_CMP_SPECIAL && cmp_hit);
  c_pwm_period: cover property (is_pwm && timer2_period_match);

endmodule

// file: test/ccp_pin_source.sv
// external signal source that stands on the far side of the unit pin
// assumes the bench resolves the pin: the unit's own drive wins while its output enable is high
`timescale 1ns/1ps
module ccp_pin_source (
  // clock
  input wire logic mclk,
  // level offered to the pin
  output logic pin_level
);
  // ----------------------------------------
  // idle level
  // ----------------------------------------
  // the source always drives, so the pin never floats to an unknown level
  initial begin
    pin_level = 1'b1;
  end

  // ----------------------------------------
  // level changes
  // ----------------------------------------
  // one change right after an edge, then hold long enough for sync, edge flop and capture
  // edges stay far more than two cycles apart so none is merged with the next
  task automatic drive(input logic v);
    @(posedge mclk);
    pin_level <= v;
    repeat (6) @(posedge mclk);
  endtask
endmodule

// file: test/ccp_capture_and_mode_control_test.sv
// self-checking bench for the capture/compare unit: registers, capture modes, compare actions
// assumes the unit sits alone on mclk with a bench-driven timer count and one pin source
`timescale 1ns/1ps
`include "ccp_consts.svh"
module ccp_capture_and_mode_control_test;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic [15:0] timer1_count = 16'h0000;
  logic [7:0] timer2_count = 8'h00;
  logic t2_match = 1'b0;
  logic [7:0] reg_rdata;
  logic unit_pin_in, unit_pin_out, unit_pin_oe, tclk_out, tclk_oe, flag, t1_rst, adc_go, src_level;
  logic [15:0] exp_v;
  logic [3:0] caps [4] = '{`CCP_M_CAP_FALL, `CCP_M_CAP_RISE, `CCP_M_CAP_RISE4, `CCP_M_CAP_RISE16};
  logic [3:0] cmps [5] = '{`CCP_M_CMP_SET, `CCP_M_CMP_SWI, `CCP_M_CMP_SPECIAL, `CCP_M_CMP_SET, `CCP_M_CMP_CLR};
  // keep: enter the mode straight from the previous one, so the latch starts high
  logic keep [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  logic outs [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
  int need [4] = '{1, 1, 4, 16};
  int n_mismatch = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_trig = 0;

  // 25 ns period
  always #12.5 mclk = ~mclk;

  // pin level: the unit's drive wins while enabled, else the source
  assign unit_pin_in = unit_pin_oe ? unit_pin_out : src_level;

  // ----------------------------------------
  // instances
  // ----------------------------------------
  // both timer bases come from the bench so compare and pwm can be steered
  ccp_capture #(.VALUE_W(16)) ccp_capture_inst (
    .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .timer1_count(timer1_count), .timer2_count(timer2_count),
    .timer2_period_match(t2_match), .unit_pin_in(unit_pin_in), .unit_pin_out(unit_pin_out),
    .unit_pin_oe(unit_pin_oe), .timer_clock_pin_out(tclk_out), .timer_clock_pin_oe(tclk_oe),
    .unit_interrupt_flag(flag), .timer1_reset(t1_rst), .adc_start(adc_go)
  );
  ccp_pin_source ccp_pin_source_inst (.mclk(mclk), .pin_level(src_level));

  // ----------------------------------------
  // monitors and hang guard
  // ----------------------------------------
  // a trigger only counts when both pulses land in the same cycle
  always @(posedge mclk) begin
    if (t1_rst === 1'b1 && adc_go === 1'b1) n_trig <= n_trig + 1;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch = n_mismatch + 1;
      test_done();
    end
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge mclk);
    reg_we <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe, so sample just past that edge
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge mclk);
    reg_re <= 1'b0;
    #1;
    chk(what, {8'h00, reg_rdata}, {8'h00, exp});
  endtask
  task automatic tmr(input logic [15:0] v);
    @(posedge mclk);
    timer1_count <= v;
  endtask
  // 8-bit timer value, with an optional one-cycle period boundary pulse
  task automatic t2(input logic [7:0] v, input logic p);
    @(posedge mclk);
    timer2_count <= v;
    t2_match <= p;
    @(posedge mclk);
    t2_match <= 1'b0;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    rd_chk("mode reset", `CCP_ADDR_MODE, 8'h00);
    rd_chk("dir reset", `CCP_ADDR_PIN_DIR, 8'hFF);
    rd_chk("flag reset", `CCP_ADDR_FLAGS, 8'h00);
    chk("pin oe reset", {15'h0000, unit_pin_oe}, 16'h0000);
    wr(8'h20, 8'h5A);
    rd_chk("unmapped", 8'h20, 8'h00);
    $display("test reset done");
    wr(`CCP_ADDR_MODE, 8'hFF);
    rd_chk("mode top bits", `CCP_ADDR_MODE, 8'h3F);
    wr(`CCP_ADDR_MODE, 8'h30);
    rd_chk("duty bits", `CCP_ADDR_MODE, 8'h30);
    wr(`CCP_ADDR_VALUE_LO, 8'hA5);
    wr(`CCP_ADDR_VALUE_HI, 8'h5A);
    rd_chk("value low", `CCP_ADDR_VALUE_LO, 8'hA5);
    rd_chk("value high", `CCP_ADDR_VALUE_HI, 8'h5A);
    wr(`CCP_ADDR_DATA_LATCH, 8'h01);
    wr(`CCP_ADDR_PIN_DIR, 8'hFA);
    rd_chk("dir rw", `CCP_ADDR_PIN_DIR, 8'hFA);
    chk("pin oe", {15'h0000, unit_pin_oe}, 16'h0001);
    chk("tclk oe", {15'h0000, tclk_oe}, 16'h0001);
    chk("tclk out", {15'h0000, tclk_out}, 16'h0001);
    wr(`CCP_ADDR_PIN_DIR, 8'hFF);
    wr(`CCP_ADDR_DATA_LATCH, 8'h00);
    $display("test registers done");
    // each mode from off, flag cleared after the change; timer moves between fall and rise
    for (int m = 0; m < 4; m++) begin
      wr(`CCP_ADDR_MODE, 8'h00);
      wr(`CCP_ADDR_MODE, {4'h0, caps[m]});
      wr(`CCP_ADDR_FLAGS, 8'h00);
      for (int i = 0; i < need[m]; i++) begin
        if (i == need[m] - 1) rd_chk("early capture", `CCP_ADDR_FLAGS, 8'h00);
        tmr(16'h1357 + 16'(m));
        ccp_pin_source_inst.drive(1'b0);
        tmr(16'h2468 + 16'(m));
        ccp_pin_source_inst.drive(1'b1);
      end
      exp_v = (m == 0) ? 16'h1357 : 16'h2468 + 16'(m);
      chk("capture flag", {15'h0000, flag}, 16'h0001);
      rd_chk("capture low", `CCP_ADDR_VALUE_LO, exp_v[7:0]);
      rd_chk("capture high", `CCP_ADDR_VALUE_HI, exp_v[15:8]);
    end
    wr(`CCP_ADDR_MODE, {4'h0, `CCP_M_CAP_RISE});
    tmr(16'h1111);
    ccp_pin_source_inst.drive(1'b0);
    ccp_pin_source_inst.drive(1'b1);
    tmr(16'h2B3C);
    ccp_pin_source_inst.drive(1'b0);
    ccp_pin_source_inst.drive(1'b1);
    rd_chk("overwrite low", `CCP_ADDR_VALUE_LO, 8'h3C);
    rd_chk("overwrite high", `CCP_ADDR_VALUE_HI, 8'h2B);
    rd_chk("flag held", `CCP_ADDR_FLAGS, 8'h04);
    // driven pin: a data latch write makes the edge itself
    wr(`CCP_ADDR_PIN_DIR, 8'hFB);
    wr(`CCP_ADDR_FLAGS, 8'h00);
    rd_chk("flag cleared", `CCP_ADDR_FLAGS, 8'h00);
    wr(`CCP_ADDR_DATA_LATCH, 8'h04);
    repeat (6) @(posedge mclk);
    chk("latch capture", {15'h0000, flag}, 16'h0001);
    chk("pin driven", {15'h0000, unit_pin_out}, 16'h0001);
    wr(`CCP_ADDR_PIN_DIR, 8'hFF);
    wr(`CCP_ADDR_DATA_LATCH, 8'h00);
    $display("test capture done");
    // compare: set, flag only (latch stays high), special after off (latch forced low), set, clear
    wr(`CCP_ADDR_MODE, 8'h00);
    wr(`CCP_ADDR_VALUE_LO, 8'h34);
    wr(`CCP_ADDR_VALUE_HI, 8'h12);
    for (int m = 0; m < 5; m++) begin
      if (!keep[m]) wr(`CCP_ADDR_MODE, 8'h00);
      tmr(16'h0000);
      wr(`CCP_ADDR_FLAGS, 8'h00);
      n_trig = 0;
      wr(`CCP_ADDR_MODE, {4'h0, cmps[m]});
      tmr(16'h1234);
      repeat (4) @(posedge mclk);
      chk("compare flag", {15'h0000, flag}, 16'h0001);
      chk("compare pin", {15'h0000, unit_pin_out}, {15'h0000, outs[m]});
      chk("special trigger", 16'(n_trig), (m == 2) ? 16'h0001 : 16'h0000);
    end
    $display("test compare done");
    // pwm: the high byte is read-only and takes the low byte only at the period boundary
    wr(`CCP_ADDR_MODE, 8'h00);
    wr(`CCP_ADDR_VALUE_LO, 8'h40);
    wr(`CCP_ADDR_MODE, 8'h2C);
    wr(`CCP_ADDR_VALUE_HI, 8'h77);
    rd_chk("pwm high byte held", `CCP_ADDR_VALUE_HI, 8'h12);
    t2(8'h40, 1'b1);
    rd_chk("pwm duty reload", `CCP_ADDR_VALUE_HI, 8'h40);
    repeat (2) @(posedge mclk);
    chk("pwm duty low bits", {15'h0000, unit_pin_out}, 16'h0001);
    t2(8'h41, 1'b0);
    repeat (2) @(posedge mclk);
    chk("pwm past duty", {15'h0000, unit_pin_out}, 16'h0000);
    wr(`CCP_ADDR_MODE, 8'h00);
    $display("test pwm done");
    test_done();
  end
endmodule
